// File: hw/io_decode_pkg.sv
// Overview of operation
// - compare only host address bits 11 to 0
// - 8-byte blocks at 0x100..0x0FF8, 8-aligned
// - parallel base 4-aligned 0x100..0x0FFC, enhanced off
// - enhanced offsets +3..+7 only when 8-aligned
// - parallel decodes +400h, +401h, +402h too
// - clock at 70/71, second pair 2-aligned
// - keyboard fixed at 60 and 64
// - power block 0x00..0x0FE7, 24-aligned
// - primary_base_high/secondary_base_high high byte, primary_base_low/secondary_base_low low byte
// - out-of-range base makes device ignore cycles at that base; clock still answers 70/71
// - device answers only while activate bit set
package io_decode_pkg;

  // ----------------------------------------------------------------
  // configuration indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_BASE1_HI = 8'h60;
  localparam logic [7:0] IDX_BASE1_LO = 8'h61;
  localparam logic [7:0] IDX_BASE2_HI = 8'h62;
  localparam logic [7:0] IDX_BASE2_LO = 8'h63;
  localparam logic [7:0] LDN_RESET = 8'h00;
  localparam logic [15:0] BASE_RESET = 16'h0000;
  localparam int ACT_BIT = 0;

  // ----------------------------------------------------------------
  // logical device numbers and storage slots
  // ----------------------------------------------------------------
  localparam int NUM_SLOTS = 7;
  localparam logic [7:0] LDN_FLOPPY = 8'h00;
  localparam logic [7:0] LDN_PARALLEL = 8'h03;
  localparam logic [7:0] LDN_SERIAL1 = 8'h04;
  localparam logic [7:0] LDN_SERIAL2 = 8'h05;
  localparam logic [7:0] LDN_CLOCK = 8'h06;
  localparam logic [7:0] LDN_KEYBOARD = 8'h07;
  localparam logic [7:0] LDN_POWER = 8'h0A;
  localparam int SLOT_FLOPPY = 0;
  localparam int SLOT_PARALLEL = 1;
  localparam int SLOT_SERIAL1 = 2;
  localparam int SLOT_SERIAL2 = 3;
  localparam int SLOT_CLOCK = 4;
  localparam int SLOT_KEYBOARD = 5;
  localparam int SLOT_POWER = 6;
  localparam logic [NUM_SLOTS-1:0] HAS_BASE1 = 7'h4F;
  localparam logic [NUM_SLOTS-1:0] HAS_BASE2 = 7'h18;

  // ----------------------------------------------------------------
  // decode targets, one bit each in the hit vector
  // ----------------------------------------------------------------
  localparam int NUM_TARGETS = 8;
  localparam int T_FLOPPY = 0;
  localparam int T_PARALLEL = 1;
  localparam int T_SERIAL1 = 2;
  localparam int T_SERIAL2 = 3;
  localparam int T_INFRARED = 4;
  localparam int T_CLOCK = 5;
  localparam int T_KEYBOARD = 6;
  localparam int T_POWER = 7;

  // ----------------------------------------------------------------
  // ranges, block sizes and fixed addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] BLK8_MIN = 16'h0100;
  localparam logic [15:0] BLK8_MAX = 16'h0FF8;
  localparam logic [15:0] PAR_MAX = 16'h0FFC;
  localparam logic [15:0] CLK2_MAX = 16'h0FFE;
  localparam logic [15:0] PWR_MAX = 16'h0FE7;
  localparam logic [11:0] PWR_ALIGN = 12'h018;
  localparam logic [11:0] BLK8_SIZE = 12'h008;
  localparam logic [11:0] PWR_SIZE = 12'h018;
  localparam logic [11:0] CLK_SIZE = 12'h002;
  localparam logic [11:0] PAR_STD_SIZE = 12'h003;
  localparam logic [11:0] PAR_EXT_FIRST = 12'h400;
  localparam logic [11:0] PAR_EXT_LAST = 12'h402;
  localparam logic [11:0] CLK_INDEX_ADDR = 12'h070;
  localparam logic [11:0] CLK_DATA_ADDR = 12'h071;
  localparam logic [11:0] KBD_DATA_ADDR = 12'h060;
  localparam logic [11:0] KBD_CMD_ADDR = 12'h064;
  localparam logic [10:0] KBD_CMD_OFFSET = 11'h004;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  localparam int CYC_W = 15;
  localparam logic [CYC_W-1:0] CYC_RESET = 15'h3000;

  typedef struct packed {
    logic aen;
    logic iow_n;
    logic ior_n;
    logic [11:0] addr;
  } io_cycle_t;

  typedef struct packed {
    logic [NUM_TARGETS-1:0] target;
    logic [10:0] offset;
    logic rd;
    logic wr;
  } io_hit_t;

endpackage

// File: hw/pin_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pins and settled values
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  // ----------------------------------------------------------------
  // three stages, a bit changes once stages two and three agree
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[i] <= RST[i];
          s2_q[i] <= RST[i];
          s3_q[i] <= RST[i];
          out_q[i] <= RST[i];
        end else begin
          s1_q[i] <= din[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            out_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

  assign dout = out_q;

endmodule
`default_nettype wire

// File: hw/io_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module io_decoder (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // host bus pins
  input wire logic [11:0] isa_addr,
  input wire logic isa_ior_n,
  input wire logic isa_iow_n,
  input wire logic isa_aen,
  // configuration register port
  input wire logic cfg_we,
  input wire logic cfg_re,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // decoded cycle
  output io_decode_pkg::io_hit_t hit
);
  import io_decode_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  io_cycle_t cyc_raw;
  io_cycle_t cyc;

  assign cyc_raw = '{aen: isa_aen, iow_n: isa_iow_n, ior_n: isa_ior_n, addr: isa_addr};

  pin_sync3 #(.W(CYC_W), .RST(CYC_RESET)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(cyc_raw),
    .dout(cyc)
  );

  // ----------------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------------
  logic [7:0] ldn_q;
  logic [NUM_SLOTS-1:0] act_q;
  logic [15:0] base1_q [NUM_SLOTS];
  logic [15:0] base2_q [NUM_SLOTS];
  logic [7:0] cfg_rdata_q;
  logic [NUM_SLOTS-1:0] slot_sel;
  logic slot_any;
  logic [2:0] slot_idx;

  // bank chosen by the device number register
  assign slot_sel[SLOT_FLOPPY] = (ldn_q == LDN_FLOPPY);
  assign slot_sel[SLOT_PARALLEL] = (ldn_q == LDN_PARALLEL);
  assign slot_sel[SLOT_SERIAL1] = (ldn_q == LDN_SERIAL1);
  assign slot_sel[SLOT_SERIAL2] = (ldn_q == LDN_SERIAL2);
  assign slot_sel[SLOT_CLOCK] = (ldn_q == LDN_CLOCK);
  assign slot_sel[SLOT_KEYBOARD] = (ldn_q == LDN_KEYBOARD);
  assign slot_sel[SLOT_POWER] = (ldn_q == LDN_POWER);
  assign slot_any = |slot_sel;

  always_comb begin
    slot_idx = 3'h0;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (slot_sel[s]) begin
        slot_idx = 3'(s);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ldn_q <= LDN_RESET;
    end else if (cfg_we && cfg_index == IDX_LDN) begin
      ldn_q <= cfg_wdata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      logic wr_here;
      assign wr_here = cfg_we && slot_sel[g];
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          act_q[g] <= 1'b0;
          base1_q[g] <= BASE_RESET;
          base2_q[g] <= BASE_RESET;
        end else if (wr_here) begin
          if (cfg_index == IDX_ACT) begin
            act_q[g] <= cfg_wdata[ACT_BIT];
          end
          if (HAS_BASE1[g] && cfg_index == IDX_BASE1_HI) begin
            base1_q[g][15:8] <= cfg_wdata;
          end
          if (HAS_BASE1[g] && cfg_index == IDX_BASE1_LO) begin
            base1_q[g][7:0] <= cfg_wdata;
          end
          if (HAS_BASE2[g] && cfg_index == IDX_BASE2_HI) begin
            base2_q[g][15:8] <= cfg_wdata;
          end
          if (HAS_BASE2[g] && cfg_index == IDX_BASE2_LO) begin
            base2_q[g][7:0] <= cfg_wdata;
          end
        end
      end
    end
  endgenerate

  // read back, unimplemented indices return zero
  logic [7:0] rd_mux;
  logic has1;
  logic has2;
  assign has1 = slot_any && HAS_BASE1[slot_idx];
  assign has2 = slot_any && HAS_BASE2[slot_idx];
  assign rd_mux = (cfg_index == IDX_LDN) ? ldn_q :
                  (slot_any && cfg_index == IDX_ACT) ? {7'h00, act_q[slot_idx]} :
                  (has1 && cfg_index == IDX_BASE1_HI) ? base1_q[slot_idx][15:8] :
                  (has1 && cfg_index == IDX_BASE1_LO) ? base1_q[slot_idx][7:0] :
                  (has2 && cfg_index == IDX_BASE2_HI) ? base2_q[slot_idx][15:8] :
                  (has2 && cfg_index == IDX_BASE2_LO) ? base2_q[slot_idx][7:0] : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_q <= 8'h00;
    end else if (cfg_re) begin
      cfg_rdata_q <= rd_mux;
    end
  end

  assign cfg_rdata = cfg_rdata_q;

  // ----------------------------------------------------------------
  // base validity
  // ----------------------------------------------------------------
  function automatic logic blk8_ok(input logic [15:0] b);
    blk8_ok = (b >= BLK8_MIN) && (b <= BLK8_MAX) && (b[2:0] == 3'h0);
  endfunction

  logic [15:0] fl_base;
  logic [15:0] pp_base;
  logic [15:0] s1_base;
  logic [15:0] s2_base;
  logic [15:0] ir_base;
  logic [15:0] ck_base;
  logic [15:0] pw_base;
  logic fl_ok;
  logic pp_ok;
  logic pp_epp;
  logic s1_ok;
  logic s2_ok;
  logic ir_ok;
  logic ck_ok;
  logic pw_ok;

  assign fl_base = base1_q[SLOT_FLOPPY];
  assign pp_base = base1_q[SLOT_PARALLEL];
  assign s1_base = base1_q[SLOT_SERIAL1];
  assign s2_base = base1_q[SLOT_SERIAL2];
  assign ir_base = base2_q[SLOT_SERIAL2];
  assign ck_base = base2_q[SLOT_CLOCK];
  assign pw_base = base1_q[SLOT_POWER];

  assign fl_ok = blk8_ok(fl_base);
  assign s1_ok = blk8_ok(s1_base);
  assign s2_ok = blk8_ok(s2_base);
  assign ir_ok = blk8_ok(ir_base);
  assign pp_ok = (pp_base >= BLK8_MIN) && (pp_base <= PAR_MAX) && (pp_base[1:0] == 2'h0);
  assign pp_epp = pp_ok && (pp_base[2] == 1'b0);
  assign ck_ok = (ck_base <= CLK2_MAX) && (ck_base[0] == 1'b0);
  assign pw_ok = (pw_base <= PWR_MAX) && (12'(pw_base[11:0] % PWR_ALIGN) == 12'h000);

  // ----------------------------------------------------------------
  // address match on the low twelve lines
  // ----------------------------------------------------------------
  logic access;
  logic [11:0] d_fl;
  logic [11:0] d_pp;
  logic [11:0] d_s1;
  logic [11:0] d_s2;
  logic [11:0] d_ir;
  logic [11:0] d_ck;
  logic [11:0] d_pw;
  logic [NUM_TARGETS-1:0] match;
  logic [10:0] off [NUM_TARGETS];
  logic ck_fixed;
  logic pp_std;
  logic pp_ext;

  assign access = (!cyc.ior_n || !cyc.iow_n) && !cyc.aen;

  assign d_fl = cyc.addr - fl_base[11:0];
  assign d_pp = cyc.addr - pp_base[11:0];
  assign d_s1 = cyc.addr - s1_base[11:0];
  assign d_s2 = cyc.addr - s2_base[11:0];
  assign d_ir = cyc.addr - ir_base[11:0];
  assign d_ck = cyc.addr - ck_base[11:0];
  assign d_pw = cyc.addr - pw_base[11:0];

  assign ck_fixed = (cyc.addr == CLK_INDEX_ADDR) || (cyc.addr == CLK_DATA_ADDR);
  assign pp_std = (d_pp < PAR_STD_SIZE) || (pp_epp && d_pp < BLK8_SIZE);
  assign pp_ext = (d_pp >= PAR_EXT_FIRST) && (d_pp <= PAR_EXT_LAST);

  assign match[T_FLOPPY] = act_q[SLOT_FLOPPY] && fl_ok && d_fl < BLK8_SIZE;
  assign match[T_PARALLEL] = act_q[SLOT_PARALLEL] && pp_ok && (pp_std || pp_ext);
  assign match[T_SERIAL1] = act_q[SLOT_SERIAL1] && s1_ok && d_s1 < BLK8_SIZE;
  assign match[T_SERIAL2] = act_q[SLOT_SERIAL2] && s2_ok && d_s2 < BLK8_SIZE;
  assign match[T_INFRARED] = act_q[SLOT_SERIAL2] && ir_ok && d_ir < BLK8_SIZE;
  assign match[T_CLOCK] = act_q[SLOT_CLOCK] &&
                          (ck_fixed || (ck_ok && d_ck < CLK_SIZE));
  assign match[T_KEYBOARD] = act_q[SLOT_KEYBOARD] &&
                             (cyc.addr == KBD_DATA_ADDR || cyc.addr == KBD_CMD_ADDR);
  assign match[T_POWER] = act_q[SLOT_POWER] && pw_ok && d_pw < PWR_SIZE;

  assign off[T_FLOPPY] = d_fl[10:0];
  assign off[T_PARALLEL] = d_pp[10:0];
  assign off[T_SERIAL1] = d_s1[10:0];
  assign off[T_SERIAL2] = d_s2[10:0];
  assign off[T_INFRARED] = d_ir[10:0];
  assign off[T_CLOCK] = ck_fixed ? {10'h000, cyc.addr[0]} : d_ck[10:0];
  assign off[T_KEYBOARD] = (cyc.addr == KBD_CMD_ADDR) ? KBD_CMD_OFFSET : 11'h000;
  assign off[T_POWER] = d_pw[10:0];

  // overlapping windows resolve to the lowest target number
  io_hit_t hit_d;
  io_hit_t hit_q;
  always_comb begin
    hit_d = '0;
    for (int t = NUM_TARGETS - 1; t >= 0; t--) begin
      if (access && match[t]) begin
        hit_d.target = NUM_TARGETS'(1) << t;
        hit_d.offset = off[t];
      end
    end
    hit_d.rd = (|hit_d.target) && !cyc.ior_n;
    hit_d.wr = (|hit_d.target) && !cyc.iow_n;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_q <= '0;
    end else begin
      hit_q <= hit_d;
    end
  end

  assign hit = hit_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  strobe_qual_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (hit_q.rd || hit_q.wr) |-> $past(!cyc.aen && (!cyc.ior_n || !cyc.iow_n)))
    else $error("decode output without a qualified host strobe");

  floppy_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hit_q.target[T_FLOPPY] |-> $past(fl_base >= 16'h0100 && fl_base <= 16'h0FF8 &&
                                     fl_base[2:0] == 3'h0))
    else $error("floppy decoded from an invalid base");

  inactive_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(!act_q[SLOT_SERIAL1]) |-> !hit_q.target[T_SERIAL1])
    else $error("inactive serial port decoded");

  infrared_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(!act_q[SLOT_SERIAL2]) |-> !hit_q.target[T_INFRARED])
    else $error("infrared window decoded while serial port two inactive");

  dma_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(cyc.aen) |-> !(|hit_q.target))
    else $error("dma address cycle decoded");

  enhanced_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (hit_q.target[T_PARALLEL] && hit_q.offset >= 11'h003 && hit_q.offset <= 11'h007)
      |-> $past(pp_base[2] == 1'b0))
    else $error("enhanced offset decoded on a 4-aligned base");

  ext_control_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (access && pp_ok && act_q[SLOT_PARALLEL] && cyc.addr == pp_base[11:0] + 12'h402 &&
     !match[T_FLOPPY])
      |=> hit_q.target[T_PARALLEL] && hit_q.offset == 11'h402)
    else $error("parallel extended control register missed");

  clock_fixed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (access && act_q[SLOT_CLOCK] && cyc.addr == 12'h071 && !(|match[T_CLOCK-1:0]))
      |=> hit_q.target[T_CLOCK] && hit_q.offset == 11'h001)
    else $error("clock data port missed");

  keyboard_cmd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (access && act_q[SLOT_KEYBOARD] && cyc.addr == 12'h064 && !(|match[T_KEYBOARD-1:0]))
      |=> hit_q.target[T_KEYBOARD] && hit_q.offset == 11'h004)
    else $error("keyboard command port missed");

  power_align_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hit_q.target[T_POWER] |-> $past(pw_base <= 16'h0FE7 && pw_base[11:0] % 12'd24 == 12'd0))
    else $error("power block decoded from a bad base");

  base_readback_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_we && !cfg_re && cfg_index == 8'h60 && ldn_q == 8'h00) ##1
    (cfg_re && !cfg_we && cfg_index == 8'h60) |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("base high byte did not read back");

endmodule
`default_nettype wire

// File: verif/isa_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module isa_host_model (
  // clock
  input wire logic sys_clk,
  // host bus pins
  output logic [11:0] isa_addr,
  output logic isa_ior_n,
  output logic isa_iow_n,
  output logic isa_aen,
  // marks a settled point for the bench monitor
  output logic look
);
  initial begin
    isa_addr = 12'h000;
    isa_ior_n = 1'b1;
    isa_iow_n = 1'b1;
    isa_aen = 1'b0;
    look = 1'b0;
  end

  // ----------------------------------------------------------------
  // one host i/o cycle, then an idle stretch with the address released
  // ----------------------------------------------------------------
  task automatic run(input logic [11:0] a, input logic rd, input logic dma);
    @(posedge sys_clk);
    isa_addr <= a;
    isa_ior_n <= !rd;
    isa_iow_n <= rd;
    isa_aen <= dma;
    repeat (6) @(posedge sys_clk);
    look <= 1'b1;
    @(posedge sys_clk);
    look <= 1'b0;
    // released lines float: show the inverse so stale values never match
    isa_addr <= ~a;
    isa_ior_n <= 1'b1;
    isa_iow_n <= 1'b1;
    isa_aen <= 1'b0;
    repeat (6) @(posedge sys_clk);
    look <= 1'b1;
    @(posedge sys_clk);
    look <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import io_decode_pkg::*;
  logic sys_clk;
  logic rst_n;
  logic cfg_we;
  logic cfg_re;
  logic [7:0] cfg_index;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic [11:0] isa_addr;
  logic isa_ior_n, isa_iow_n, isa_aen, look;
  io_hit_t hit;
  int fails;
  int comparisons;
  io_hit_t exp_hit_q[$];
  logic [7:0] exp_rd_q[$];
  logic rd_pend, rd_pend2;
  logic [10:0] par_off[5] = '{11'h000, 11'h003, 11'h007, 11'h400, 11'h402};

  io_decoder i_io_decoder (.sys_clk(sys_clk), .rst_n(rst_n), .isa_addr(isa_addr),
    .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n), .isa_aen(isa_aen), .cfg_we(cfg_we),
    .cfg_re(cfg_re), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .hit(hit));
  isa_host_model i_isa_host_model (.sys_clk(sys_clk), .isa_addr(isa_addr),
    .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n), .isa_aen(isa_aen), .look(look));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // compares and monitor
  // ----------------------------------------------------------------
  task automatic chk_hit(input io_hit_t exp, input io_hit_t got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] hit expected %h seen %h", exp, got);
    end
  endtask

  task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] cfg_rdata expected %h seen %h", exp, got);
    end
  endtask

  always @(posedge sys_clk) begin
    rd_pend <= cfg_re;
    rd_pend2 <= rd_pend;
  end

  always @(negedge sys_clk) begin
    if (rd_pend2 === 1'b1) begin
      chk_byte(exp_rd_q.pop_front(), cfg_rdata);
    end
    if (look === 1'b1) begin
      chk_hit(exp_hit_q.pop_front(), hit);
    end
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge sys_clk);
    cfg_we <= 1'b1;
    cfg_index <= idx;
    cfg_wdata <= val;
    @(posedge sys_clk);
    cfg_we <= 1'b0;
  endtask

  task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
    exp_rd_q.push_back(exp);
    @(posedge sys_clk);
    cfg_re <= 1'b1;
    cfg_index <= idx;
    @(posedge sys_clk);
    cfg_re <= 1'b0;
  endtask

  task automatic cfg_wr_rd(input logic [7:0] idx, input logic [7:0] val);
    exp_rd_q.push_back(val);
    @(posedge sys_clk);
    cfg_we <= 1'b1;
    cfg_index <= idx;
    cfg_wdata <= val;
    @(posedge sys_clk);
    cfg_we <= 1'b0;
    cfg_re <= 1'b1;
    @(posedge sys_clk);
    cfg_re <= 1'b0;
  endtask

  task automatic setdev(input logic [7:0] ldn, input logic [15:0] base, input logic act);
    cfg_wr(IDX_LDN, ldn);
    cfg_wr(IDX_BASE1_HI, base[15:8]);
    cfg_wr(IDX_BASE1_LO, base[7:0]);
    cfg_wr(IDX_ACT, {7'h00, act});
  endtask

  task automatic io(input logic [11:0] a, input logic rd, input logic dma, input io_hit_t exp);
    exp_hit_q.push_back(exp);
    exp_hit_q.push_back('0);
    i_isa_host_model.run(a, rd, dma);
  endtask

  function automatic io_hit_t hx(input int t, input logic [10:0] off, input logic rd);
    io_hit_t h;
    h = '0;
    h.target[t] = 1'b1;
    h.offset = off;
    h.rd = rd;
    h.wr = !rd;
    return h;
  endfunction

  task automatic done(input string name);
    $display("test %s finished, comparisons %0d fails %0d", name, comparisons, fails);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    $display("[ERR] run length expected bounded seen hung");
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] b;
    logic [10:0] off;
    logic rd;
    rst_n = 1'b0;
    cfg_we = 1'b0;
    cfg_re = 1'b0;
    cfg_index = 8'h00;
    cfg_wdata = 8'h00;
    fails = 0;
    comparisons = 0;
    void'($urandom(32'hBD03));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      cfg_rd(IDX_BASE1_HI + 8'(i), 8'h00);
    end
    cfg_rd(IDX_ACT, 8'h00);
    cfg_wr(8'h31, 8'h5A);
    cfg_rd(8'h31, 8'h00);
    done("reset");
    setdev(LDN_FLOPPY, 16'h03F0, 1'b1);
    cfg_wr_rd(IDX_BASE1_HI, 8'h03);
    cfg_rd(IDX_BASE1_HI, 8'h03);
    cfg_rd(IDX_BASE1_LO, 8'hF0);
    cfg_rd(IDX_ACT, 8'h01);
    io(12'h3F5, 1'b1, 1'b0, hx(T_FLOPPY, 11'h005, 1'b1));
    io(12'h3F7, 1'b0, 1'b0, hx(T_FLOPPY, 11'h007, 1'b0));
    io(12'h3F8, 1'b1, 1'b0, '0);
    io(12'h3F0, 1'b1, 1'b1, '0);
    cfg_wr(IDX_ACT, 8'h00);
    io(12'h3F0, 1'b1, 1'b0, '0);
    setdev(LDN_FLOPPY, 16'h00F8, 1'b1);
    io(12'h0F8, 1'b1, 1'b0, '0);
    setdev(LDN_FLOPPY, 16'h13F0, 1'b1);
    io(12'h3F0, 1'b1, 1'b0, '0);
    setdev(LDN_FLOPPY, 16'h0FF8, 1'b1);
    io(12'hFFF, 1'b1, 1'b0, hx(T_FLOPPY, 11'h007, 1'b1));
    done("floppy");
    setdev(LDN_PARALLEL, 16'h0378, 1'b1);
    foreach (par_off[i]) begin
      io(12'h378 + 12'(par_off[i]), 1'b1, 1'b0, hx(T_PARALLEL, par_off[i], 1'b1));
    end
    io(12'h77B, 1'b1, 1'b0, '0);
    setdev(LDN_PARALLEL, 16'h037C, 1'b1);
    io(12'h37F, 1'b1, 1'b0, '0);
    io(12'h37E, 1'b0, 1'b0, hx(T_PARALLEL, 11'h002, 1'b0));
    io(12'h77D, 1'b1, 1'b0, hx(T_PARALLEL, 11'h401, 1'b1));
    done("parallel");
    setdev(LDN_SERIAL1, 16'h02F8, 1'b1);
    io(12'h2FF, 1'b1, 1'b0, hx(T_SERIAL1, 11'h007, 1'b1));
    setdev(LDN_SERIAL2, 16'h03E8, 1'b1);
    cfg_wr(IDX_BASE2_HI, 8'h02);
    cfg_wr(IDX_BASE2_LO, 8'hE0);
    io(12'h3E8, 1'b0, 1'b0, hx(T_SERIAL2, 11'h000, 1'b0));
    io(12'h2E3, 1'b1, 1'b0, hx(T_INFRARED, 11'h003, 1'b1));
    done("serial");
    setdev(LDN_CLOCK, 16'h0000, 1'b1);
    cfg_wr(IDX_BASE2_HI, 8'h00);
    cfg_wr(IDX_BASE2_LO, 8'hA2);
    io(12'h070, 1'b1, 1'b0, hx(T_CLOCK, 11'h000, 1'b1));
    io(12'h071, 1'b0, 1'b0, hx(T_CLOCK, 11'h001, 1'b0));
    io(12'h0A3, 1'b1, 1'b0, hx(T_CLOCK, 11'h001, 1'b1));
    done("clock");
    setdev(LDN_KEYBOARD, 16'h0300, 1'b1);
    cfg_rd(IDX_BASE1_LO, 8'h00);
    io(12'h060, 1'b1, 1'b0, hx(T_KEYBOARD, 11'h000, 1'b1));
    io(12'h064, 1'b0, 1'b0, hx(T_KEYBOARD, 11'h004, 1'b0));
    io(12'h062, 1'b1, 1'b0, '0);
    done("keyboard");
    setdev(LDN_POWER, 16'h00C0, 1'b1);
    io(12'h0D7, 1'b1, 1'b0, hx(T_POWER, 11'h017, 1'b1));
    io(12'h0D8, 1'b1, 1'b0, '0);
    setdev(LDN_POWER, 16'h00C8, 1'b1);
    io(12'h0C8, 1'b1, 1'b0, '0);
    done("power");
    for (int n = 0; n < 4; n++) begin
      b = 16'((($urandom % 480) + 32) << 3);
      off = 11'($urandom % 8);
      rd = 1'($urandom % 2);
      setdev(LDN_FLOPPY, b, 1'b1);
      io(b[11:0] + 12'(off), rd, 1'b0, hx(T_FLOPPY, off, rd));
    end
    done("random");
    repeat (4) @(posedge sys_clk);
    if (exp_hit_q.size() != 0 || exp_rd_q.size() != 0) begin
      fails++;
      $display("[ERR] pending results expected 0 seen %0d", exp_hit_q.size());
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
